// *** bench/radio_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module radio_peer
  import mac_tx_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    rst_n,
  input  wire logic    tx_start,
  input  wire tx_hdr_t tx_hdr,
  input  wire logic    ack_en,
  output logic         tx_done,
  output logic         ack_rx
);
  logic [2:0] cnt_q;
  logic       bc_q;
  // air time of three cycles, then the far peer answers two cycles later
  always @(posedge clk_sys) begin
    tx_done <= 1'b0;
    ack_rx  <= 1'b0;
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (tx_start) begin
      cnt_q <= 3'h1;
      bc_q  <= tx_hdr.bcast;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h3) tx_done <= 1'b1;
      if (cnt_q == 3'h5) begin
        ack_rx <= ack_en & ~bc_q;
        cnt_q  <= 3'h0;
      end
    end
  end
endmodule : radio_peer
`default_nettype wire

// *** bench/test_mac_tx_addressing_retry.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_mac_tx_addressing_retry
  import mac_tx_pkg::*;
;
  logic        clk_sys = 1'b0, rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, sib = 1'b0, taken, tx_start, tx_done, ack_rx;
  logic [7:0]  energy = 8'h10;
  tx_hdr_t     hdr, hdr_seen;
  logic        rx_valid = 1'b0, rx_for_us = 1'b0, wake_cyc = 1'b0, ack_en = 1'b1;
  logic        rx_bcast = 1'b0, rx_poll = 1'b0, wake_pin = 1'b0;
  logic        ack_send, poll_send, ack_fail, indirect_drop;
  logic [63:0] serial = 64'h0123456789ABCDEF;
  int          n_fail = 0, n_compared = 0, n_start = 0, n_afail = 0, n_ack = 0, n_poll = 0;
  int          s0, f0, n_drop = 0;

  always #2.5 clk_sys = ~clk_sys;

  mac_tx_addressing_retry #(.ACK_WAIT(20), .BO_SLOT(4), .TICK(50)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_number(serial),
    .serial_input_buffer(sib), .tx_data_taken(taken), .energy_level(energy),
    .tx_start(tx_start), .tx_hdr(hdr), .tx_done(tx_done), .ack_rx(ack_rx),
    .rx_valid(rx_valid), .rx_for_us(rx_for_us), .rx_bcast(rx_bcast), .rx_poll(rx_poll),
    .ack_send(ack_send), .wake_cyclic(wake_cyc), .wake_pin(wake_pin),
    .poll_send(poll_send), .ack_fail(ack_fail), .indirect_drop(indirect_drop));

  radio_peer u_peer (.clk_sys(clk_sys), .rst_n(rst_n), .tx_start(tx_start), .tx_hdr(hdr),
    .ack_en(ack_en), .tx_done(tx_done), .ack_rx(ack_rx));

  // pulse outputs are tallied so a scenario can compare deltas over its window
  always @(posedge clk_sys) begin
    if (tx_start === 1'b1) n_start++;
    if (ack_fail === 1'b1) n_afail++;
    if (ack_send === 1'b1) n_ack++;
    if (poll_send === 1'b1) n_poll++;
    if (indirect_drop === 1'b1) n_drop++;
  end

  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {32'h0, e}, {32'h0, reg_rdata});
  endtask : rd

  // offer one frame, then count radio sends and failures over a generous window
  task automatic send(input bit h, input logic sl, input logic [63:0] s, input logic dl,
                      input logic [63:0] d, input logic bc, input int st, input int fl);
    int i;
    @(posedge clk_sys);
    sib <= 1'b1;
    s0 = n_start;
    f0 = n_afail;
    for (i = 0; i < 200 && taken !== 1'b1; i++) @(posedge clk_sys);
    if (i == 200) begin
      n_fail++;
      end_sim();
    end
    hdr_seen = hdr;
    sib <= 1'b0;
    repeat (600) @(posedge clk_sys);
    if (h) begin
      chk("src_long", {63'h0, sl}, {63'h0, hdr_seen.src_long});
      chk("src", s, hdr_seen.src);
      chk("dst_long", {63'h0, dl}, {63'h0, hdr_seen.dst_long});
      chk("dst", d, hdr_seen.dst);
    end
    chk("bcast", {63'h0, bc}, {63'h0, hdr_seen.bcast});
    chk("tx_start count", st, n_start - s0);
    chk("ack_fail count", fl, n_afail - f0);
  endtask : send

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_SRC, {16'h0, SRC_RESET});
    rd(REG_RETRY, {24'h0, RETRY_RESET});
    rd(REG_CCA, {24'h0, CCA_RESET});
    wr(8'hFC, 32'h5A5A5A5A);
    rd(8'hFC, 32'h0);
    wr(REG_SRC, 32'h1234);
    wr(REG_DST_HI, 32'h0);
    wr(REG_DST_LO, 32'h2);
    send(1, 0, 64'h1234, 0, 64'h2, 0, 1, 0);
    wr(REG_SRC, 32'hFFFD);
    send(1, 0, 64'hFFFD, 0, 64'h2, 0, 1, 0);
    wr(REG_SRC, 32'hFFFE);
    wr(REG_DST_HI, 32'h1);
    send(1, 1, serial, 1, 64'h0000000100000002, 0, 1, 0);
    wr(REG_SRC, 32'hFFFF);
    wr(REG_DST_HI, 32'h0);
    wr(REG_DST_LO, 32'hFFFE);
    send(1, 1, serial, 1, 64'h000000000000FFFE, 0, 1, 0);
    wr(REG_DST_LO, 32'h2);
    ack_en <= 1'b0;
    send(0, 0, 0, 0, 0, 0, 4, 1);
    wr(REG_DST_LO, BCAST_LOW);
    wr(REG_RETRY, 32'h0);
    send(0, 0, 0, 0, 0, 1, 1, 0);
    ack_en <= 1'b1;
    wr(REG_RETRY, 32'h1);
    send(0, 0, 0, 0, 0, 1, 3, 0);
    wr(REG_DST_LO, 32'h2);
    energy <= CCA_RESET;
    send(0, 0, 0, 0, 0, 0, 1, 0);
    energy <= CCA_RESET + 8'h01;
    send(0, 0, 0, 0, 0, 0, 0, 1);
    energy <= 8'h10;
    s0 = n_poll;
    wr(REG_CMD, 32'h1);
    repeat (20) @(posedge clk_sys);
    chk("poll after command", 1, n_poll - s0);
    @(posedge clk_sys);
    wake_cyc <= 1'b1;
    @(posedge clk_sys);
    wake_cyc <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("poll after wake", 2, n_poll - s0);
    // pin wake polls only once the pin-sleep poll bit is set
    @(posedge clk_sys);
    wake_pin <= 1'b1;
    @(posedge clk_sys);
    wake_pin <= 1'b0;
    wr(REG_CTRL, 32'h4);
    @(posedge clk_sys);
    wake_pin <= 1'b1;
    @(posedge clk_sys);
    wake_pin <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("poll after pin wake", 3, n_poll - s0);
    wr(REG_CTRL, 32'h0);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    @(posedge clk_sys);
    rx_for_us <= 1'b1;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_for_us <= 1'b0;
    // a broadcast frame must not be acknowledged
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_for_us <= 1'b1;
    rx_bcast <= 1'b1;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_for_us <= 1'b0;
    rx_bcast <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("acks sent", 1, n_ack);
    wr(REG_CMD, 32'h2);
    rd(REG_SRC, {16'h0, SRC_RESERVED});
    // coordinator with a sleeping peer: two frames held, the third dropped
    wr(REG_CMD, 32'h4);
    wr(REG_CTRL, 32'h1);
    wr(REG_SLEEP, 32'hFF);
    wr(REG_IDLE, 32'h10);
    send(0, 0, 0, 0, 0, 0, 0, 0);
    chk("indirect", 1, hdr.indirect);
    send(0, 0, 0, 0, 0, 0, 0, 0);
    send(0, 0, 0, 0, 0, 0, 0, 0);
    chk("drops", 1, n_drop);
    rd(REG_STATUS, 32'h00010012);
    // a poll frees one slot and opens the awake window
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_for_us <= 1'b1;
    rx_poll <= 1'b1;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_for_us <= 1'b0;
    rx_poll <= 1'b0;
    send(0, 0, 0, 0, 0, 0, 1, 0);
    chk("direct while awake", 0, hdr.indirect);
    repeat (400) @(posedge clk_sys);
    send(0, 0, 0, 0, 0, 0, 0, 0);
    chk("drops after poll", 1, n_drop);
    rd(REG_STATUS, 32'h00010012);
    end_sim();
  end
endmodule : test_mac_tx_addressing_retry
`default_nettype wire

// *** hw/mac_tx_addressing_retry.sv ***
// Function
// R1: long serial source when setting 0xFFFE or above
// R2: short setting below 0xFFFE used as source
// R3: short destination only if high zero, low small
// R4: 0x0000FFFF with high zero is broadcast
// R5: broadcast sends one, or retry plus two
// R6: acknowledge each good unicast addressed here
// R7: unicast resent up to three more times
// R8: association sets source setting to 0xFFFE
// R9: coordinator only indirect, at most two held
// R10: sleep period zero means direct only
// R11: indirect kept for period, sent on poll; here a poll only frees a slot, no frame is sent
// R12: direct while peer awake within idle time
// R13: only addressed traffic restarts the idle timer
// R14: end device polls on cyclic wake, pin optional
// R15: force poll command polls immediately
// R16: no transmit while energy above threshold
// R17: backoff from exponent, zero gives no delay
// R18: mac mode zero gives two cca retries
// R19: broadcast and zero-retry unicast get two retries
// R20: idle leaves for transmit on buffered data
// R21: coordinator when enable one, else end device
// R22: fixed ack wait, expiry is one failed attempt
// R23: third indirect dropped and counted as failure
`timescale 1ns/1ps
`default_nettype none
module mac_tx_addressing_retry
  import mac_tx_pkg::*;
#(
  parameter int ACK_WAIT = ACK_WAIT_CYC,
  parameter int BO_SLOT  = BACKOFF_CYC,
  parameter int TICK     = TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic [63:0] serial_number,     // factory serial, high word above low
  input  wire logic        serial_input_buffer,  // host data waiting
  output logic             tx_data_taken,
  input  wire logic [7:0]  energy_level,
  output logic             tx_start,
  output tx_hdr_t          tx_hdr,
  input  wire logic        tx_done,
  input  wire logic        ack_rx,
  input  wire logic        rx_valid,          // good frame received
  input  wire logic        rx_for_us,
  input  wire logic        rx_bcast,
  input  wire logic        rx_poll,           // received frame is a data request
  output logic             ack_send,
  input  wire logic        wake_cyclic,
  input  wire logic        wake_pin,
  output logic             poll_send,
  output logic             ack_fail,
  output logic             indirect_drop
);

  typedef enum {S_IDLE, S_BACKOFF, S_CCA, S_SEND, S_WAIT, S_HOLD} st_t;

  // host settings
  logic [2:0]  ctrl_q;
  logic [15:0] src_q;
  logic [31:0] dst_hi_q, dst_lo_q;
  logic [7:0]  retry_q, cca_q, sleep_q, idle_q;
  logic [2:0]  be_q;
  logic [7:0]  fail_cnt_q;
  st_t         st_q;
  logic [31:0] tmr_q;
  logic [7:0]  copies_q;
  logic [3:0]  ack_try_q;
  logic [1:0]  cca_try_q;
  logic [15:0] lfsr_q;
  logic [7:0]  awake_q;     // remaining idle ticks of the peer
  logic [31:0] tick_q;
  logic        tick;
  logic [1:0]  held_q;      // indirect slots in use
  logic [7:0]  age_q [MAX_INDIRECT];
  logic        coord, is_bcast, want_ind;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && reg_addr == a;
  endfunction : wr_hit

  assign coord    = ctrl_q[CTRL_COORD];  // R21
  assign is_bcast = dst_hi_q == 32'h0 && dst_lo_q == BCAST_LOW;  // R4
  // indirect only on a coordinator with sleep period and a sleeping peer
  assign want_ind = coord && sleep_q != 8'h0 && awake_q == 8'h0 && !is_bcast;  // R9 R10 R12

  // register writes; association overrides the source setting
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= 3'h0;
      src_q <= SRC_RESET;
      dst_hi_q <= 32'h0;
      dst_lo_q <= 32'h0;
      retry_q <= RETRY_RESET;
      sleep_q <= 8'h0;
      idle_q <= 8'h0;
      cca_q <= CCA_RESET;
      be_q <= BE_RESET;
    end else begin
      if (wr_hit(REG_CTRL)) ctrl_q <= reg_wdata[2:0];
      if (wr_hit(REG_SRC)) src_q <= reg_wdata[15:0];
      if (wr_hit(REG_CMD) && reg_wdata[CMD_ASSOC] && !coord) src_q <= SRC_RESERVED;  // R8
      if (wr_hit(REG_DST_HI)) dst_hi_q <= reg_wdata;
      if (wr_hit(REG_DST_LO)) dst_lo_q <= reg_wdata;
      if (wr_hit(REG_RETRY)) retry_q <= reg_wdata[7:0];
      if (wr_hit(REG_SLEEP)) sleep_q <= reg_wdata[7:0];
      if (wr_hit(REG_IDLE)) idle_q <= reg_wdata[7:0];
      if (wr_hit(REG_CCA)) cca_q <= reg_wdata[7:0];
      if (wr_hit(REG_BACKOFF)) be_q <= reg_wdata[2:0];
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) reg_rdata <= 32'h0;
    else if (!reg_rd) reg_rdata <= 32'h0;
    else if (reg_addr == REG_CTRL) reg_rdata <= {29'h0, ctrl_q};
    else if (reg_addr == REG_SRC) reg_rdata <= {16'h0, src_q};
    else if (reg_addr == REG_DST_HI) reg_rdata <= dst_hi_q;
    else if (reg_addr == REG_DST_LO) reg_rdata <= dst_lo_q;
    else if (reg_addr == REG_RETRY) reg_rdata <= {24'h0, retry_q};
    else if (reg_addr == REG_SLEEP) reg_rdata <= {24'h0, sleep_q};
    else if (reg_addr == REG_IDLE) reg_rdata <= {24'h0, idle_q};
    else if (reg_addr == REG_CCA) reg_rdata <= {24'h0, cca_q};
    else if (reg_addr == REG_BACKOFF) reg_rdata <= {29'h0, be_q};
    else if (reg_addr == REG_STATUS)
      reg_rdata <= {8'h0, fail_cnt_q, awake_q, 3'h0, st_q == S_IDLE, 2'h0, held_q};
    else reg_rdata <= 32'h0;
  end

  // header forming; both source and destination decided at launch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) tx_hdr <= '0;
    else if (st_q == S_IDLE && serial_input_buffer) begin
      tx_hdr.src_long <= src_q >= SRC_RESERVED;  // R1
      tx_hdr.src <= (src_q >= SRC_RESERVED) ? serial_number : {48'h0, src_q};  // R1 R2
      tx_hdr.dst_long <= !(dst_hi_q == 32'h0 && dst_lo_q < SHORT_DST_LIMIT);  // R3
      tx_hdr.dst <= (dst_hi_q == 32'h0 && dst_lo_q < SHORT_DST_LIMIT)
                    ? {48'h0, dst_lo_q[15:0]} : {dst_hi_q, dst_lo_q};  // R3
      tx_hdr.bcast <= is_bcast;  // R4
      tx_hdr.indirect <= want_ind;
    end
  end

  // free-running tick for sleep and idle times, lfsr for backoff
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_q <= 32'h0;
      lfsr_q <= 16'hACE1;
    end else begin
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  assign tick = tick_q == 32'(TICK - 1);

  // peer awake window: addressed traffic restarts it, broadcast leaves it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) awake_q <= 8'h0;
    else if (rx_valid && rx_for_us && !rx_bcast) awake_q <= idle_q;  // R12 R13
    else if (tick && awake_q != 8'h0) awake_q <= awake_q - 8'h1;
  end

  // transmit sequencer: backoff, cca, send, ack wait, resends
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      tmr_q <= 32'h0;
      copies_q <= 8'h0;
      ack_try_q <= 4'h0;
      cca_try_q <= 2'h0;
      tx_start <= 1'b0;
      tx_data_taken <= 1'b0;
      ack_fail <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      tx_data_taken <= 1'b0;
      ack_fail <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (serial_input_buffer) begin  // R20
            tx_data_taken <= 1'b1;
            ack_try_q <= 4'h0;
            cca_try_q <= 2'h0;
            copies_q <= (is_bcast && retry_q != 8'h0) ? retry_q + BCAST_EXTRA : 8'h1;  // R5
            if (want_ind) st_q <= S_HOLD;  // R9
            else begin
              tmr_q <= (be_q == 3'h0) ? 32'h0 : 32'(BO_SLOT) * (32'(lfsr_q) & ((32'h1 << be_q) - 32'h1));
              st_q <= S_BACKOFF;  // R17
            end
          end
        end
        S_BACKOFF: begin
          if (tmr_q == 32'h0) st_q <= S_CCA;  // R17
          else tmr_q <= tmr_q - 32'h1;
        end
        S_CCA: begin
          if (energy_level <= cca_q) begin  // R16
            tx_start <= 1'b1;
            st_q <= S_SEND;
          // broadcast and zero-retry unicast keep their cca retries whatever the mac mode
          end else if (cca_try_q < CCA_RETRIES
                       && (!ctrl_q[CTRL_MM] || is_bcast || retry_q == 8'h0)) begin  // R18 R19
            cca_try_q <= cca_try_q + 2'h1;
            tmr_q <= 32'(BO_SLOT);
            st_q <= S_BACKOFF;
          end else begin
            ack_fail <= !is_bcast;
            st_q <= S_IDLE;
          end
        end
        S_SEND: begin
          if (tx_done) begin
            tmr_q <= 32'(ACK_WAIT - 1);
            if (is_bcast) begin
              copies_q <= copies_q - 8'h1;  // R5
              cca_try_q <= 2'h0;
              st_q <= (copies_q == 8'h1) ? S_IDLE : S_CCA;
            end else st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (ack_rx) st_q <= S_IDLE;
          else if (tmr_q == 32'h0) begin  // R22
            if (ack_try_q == ACK_RESENDS) begin
              ack_fail <= 1'b1;  // R7
              st_q <= S_IDLE;
            end else begin
              ack_try_q <= ack_try_q + 4'h1;  // R7
              cca_try_q <= 2'h0;
              st_q <= S_CCA;
            end
          end else tmr_q <= tmr_q - 32'h1;
        end
        S_HOLD: st_q <= S_IDLE;  // handed to the indirect store
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // indirect store: two slots aged by the sleep period, one slot freed on poll without a transmit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      held_q <= 2'h0;
      indirect_drop <= 1'b0;
      for (int i = 0; i < MAX_INDIRECT; i++) age_q[i] <= 8'h0;
    end else begin
      indirect_drop <= 1'b0;
      if (st_q == S_HOLD) begin
        if (held_q == 2'(MAX_INDIRECT)) indirect_drop <= 1'b1;  // R23
        else begin
          age_q[held_q[0]] <= sleep_q;  // R11
          held_q <= held_q + 2'h1;
        end
      end else if (held_q != 2'h0 && rx_valid && rx_poll && rx_for_us) begin
        age_q[0] <= age_q[1];  // R11
        held_q <= held_q - 2'h1;
      end else if (tick && held_q != 2'h0 && age_q[0] <= 8'h1) begin
        age_q[0] <= age_q[1] - 8'h1;  // R11
        held_q <= held_q - 2'h1;
      end else if (tick) begin
        for (int i = 0; i < MAX_INDIRECT; i++)
          if (age_q[i] != 8'h0) age_q[i] <= age_q[i] - 8'h1;
      end
    end
  end

  // acknowledge, polls and failure count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_send <= 1'b0;
      poll_send <= 1'b0;
      fail_cnt_q <= 8'h0;
    end else begin
      ack_send <= rx_valid && rx_for_us && !rx_bcast;  // R6
      poll_send <= !coord && (wake_cyclic || (wake_pin && ctrl_q[CTRL_PINPOLL])
                   || (wr_hit(REG_CMD) && reg_wdata[CMD_POLL]));  // R14 R15
      if (ack_fail || indirect_drop) fail_cnt_q <= fail_cnt_q + 8'h1;  // set wins over clear
      else if (wr_hit(REG_CMD) && reg_wdata[CMD_CLRFAIL]) fail_cnt_q <= 8'h0;
    end
  end

  property p_no_tx_busy;  // R16
    @(posedge clk_sys) disable iff (!rst_n)
      tx_start |-> $past(energy_level) <= $past(cca_q);
  endproperty
  a_no_tx_busy: assert property (p_no_tx_busy) else $error("sent on busy channel"); // R16

  property p_src_long;  // R1
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == S_IDLE && serial_input_buffer && src_q >= SRC_RESERVED)
        |=> tx_hdr.src == serial_number;
  endproperty
  a_src_long: assert property (p_src_long) else $error("long source not used"); // R1

  property p_src_short;  // R2
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == S_IDLE && serial_input_buffer && src_q < SRC_RESERVED)
        |=> !tx_hdr.src_long && tx_hdr.src[15:0] == $past(src_q);
  endproperty
  a_src_short: assert property (p_src_short) else $error("short source wrong"); // R2

  property p_bcast_flag;  // R4
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == S_IDLE && serial_input_buffer) |=> tx_hdr.bcast == $past(is_bcast);
  endproperty
  a_bcast_flag: assert property (p_bcast_flag) else $error("broadcast flag wrong"); // R4

  property p_ack_reply;  // R6
    @(posedge clk_sys) disable iff (!rst_n)
      (rx_valid && rx_for_us && !rx_bcast) |=> ack_send;
  endproperty
  a_ack_reply: assert property (p_ack_reply) else $error("no acknowledgement sent"); // R6

  property p_resend_limit;  // R7
    @(posedge clk_sys) disable iff (!rst_n) ack_try_q <= ACK_RESENDS;
  endproperty
  a_resend_limit: assert property (p_resend_limit) else $error("too many resends"); // R7

  property p_held_max;  // R9
    @(posedge clk_sys) disable iff (!rst_n) held_q <= 2'(MAX_INDIRECT);
  endproperty
  a_held_max: assert property (p_held_max) else $error("indirect store overfull"); // R9

  property p_force_poll;  // R15
    @(posedge clk_sys) disable iff (!rst_n)
      (wr_hit(REG_CMD) && reg_wdata[CMD_POLL] && !coord) |=> poll_send;
  endproperty
  a_force_poll: assert property (p_force_poll) else $error("force poll lost"); // R15

  property p_cca_retry;  // R18
    @(posedge clk_sys) disable iff (!rst_n) cca_try_q <= CCA_RETRIES;
  endproperty
  a_cca_retry: assert property (p_cca_retry) else $error("cca retries exceeded"); // R18

endmodule : mac_tx_addressing_retry
`default_nettype wire

// *** hw/mac_tx_pkg.sv ***
package mac_tx_pkg;
  // address values
  localparam logic [15:0] SRC_RESERVED    = 16'hFFFE;  // this and above select the long source
  localparam logic [31:0] BCAST_LOW       = 32'h0000FFFF;
  localparam logic [31:0] SHORT_DST_LIMIT = 32'h0000FFFE;
  // attempt limits
  localparam logic [3:0]  ACK_RESENDS     = 4'h3;      // resends after the first try
  localparam logic [1:0]  CCA_RETRIES     = 2'h2;
  localparam logic [7:0]  BCAST_EXTRA     = 8'h02;     // copies beyond the retry setting
  localparam int          MAX_INDIRECT    = 2;
  // timing
  localparam int          CLK_MHZ         = 200;
  localparam int          ACK_WAIT_US     = 864;       // fixed acknowledgement wait
  localparam int          ACK_WAIT_CYC    = ACK_WAIT_US * CLK_MHZ;
  localparam int          BACKOFF_UNIT_US = 320;       // one backoff slot
  localparam int          BACKOFF_CYC     = BACKOFF_UNIT_US * CLK_MHZ;
  localparam int          TICK_US         = 10000;     // sleep and idle settings count in 10 ms
  localparam int          TICK_CYC        = TICK_US * CLK_MHZ;
  // register offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;  // [0] coordinator, [1] mac mode, [2] pin-sleep poll
  localparam logic [7:0]  REG_SRC     = 8'h04;
  localparam logic [7:0]  REG_DST_HI  = 8'h08;
  localparam logic [7:0]  REG_DST_LO  = 8'h0C;
  localparam logic [7:0]  REG_RETRY   = 8'h10;
  localparam logic [7:0]  REG_SLEEP   = 8'h14;
  localparam logic [7:0]  REG_IDLE    = 8'h18;
  localparam logic [7:0]  REG_CCA     = 8'h1C;
  localparam logic [7:0]  REG_BACKOFF = 8'h20;
  localparam logic [7:0]  REG_STATUS  = 8'h24;  // read: state and counters
  localparam logic [7:0]  REG_CMD     = 8'h28;  // write: [0] force poll, [1] associated, [2] clear fail
  localparam int          CTRL_COORD  = 0;
  localparam int          CTRL_MM     = 1;
  localparam int          CTRL_PINPOLL = 2;
  localparam int          CMD_POLL    = 0;
  localparam int          CMD_ASSOC   = 1;
  localparam int          CMD_CLRFAIL = 2;
  localparam logic [15:0] SRC_RESET   = 16'h0000;
  localparam logic [7:0]  RETRY_RESET = 8'h0A;
  localparam logic [7:0]  CCA_RESET   = 8'h2C;
  localparam logic [2:0]  BE_RESET    = 3'h0;
  // frame header handed to the radio
  typedef struct packed {
    logic        src_long;
    logic [63:0] src;
    logic        dst_long;
    logic [63:0] dst;
    logic        bcast;
    logic        indirect;
  } tx_hdr_t;
endpackage : mac_tx_pkg
